// [core/spc_port.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_port (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        prog_serial_clock,
	input  wire logic        prog_serial_data_in,
	output logic             prog_serial_data_out,
	output logic             prog_serial_data_oe,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	spc_pkg::spc_state_t q;         // all control state
	spc_pkg::spc_state_t n;         // next value of q
	logic [7:0]  cfg_mem [16];      // configuration bytes
	logic [7:0]  id_mem  [8];       // id locations
	logic [7:0]  pm_mem  [65536];   // program memory
	logic [7:0]  ee_mem  [spc_pkg::EE_DEPTH]; // data eeprom
	logic [7:0]  pm_q;              // program byte at pointer
	logic [7:0]  ee_q;              // eeprom byte at low address byte
	logic [7:0]  tbl_byte;          // byte the table read returns
	logic        fall;              // falling edge of serial clock
	logic        cfg_we;            // config byte write strobe
	logic [3:0]  cfg_wa;            // config byte index
	logic [7:0]  cfg_wd;            // config byte value
	logic        ld_we;             // preload strobe from the bus
	logic        ee_rd;             // eeprom read into latch
	logic        tr_done;           // table read finished
	logic        core_exec;         // core instruction finished
	logic [15:0] np;                // payload including newest bit
	logic [15:0] ld_adr;            // preload address
	logic [1:0]  ld_sel;            // preload target

	// read decode for movf; the status view reads the fields directly
	function automatic logic [7:0] sfr_rd(input spc_pkg::spc_state_t s,
		input logic [7:0] f);
		unique case (f)
			spc_pkg::SFR_TLAT: sfr_rd = s.tlat;
			spc_pkg::SFR_PTRL: sfr_rd = s.ptr[7:0];
			spc_pkg::SFR_PTRH: sfr_rd = s.ptr[15:8];
			spc_pkg::SFR_PTRU: sfr_rd = {2'h0, s.ptr[21:16]};
			spc_pkg::SFR_NVM:  sfr_rd = s.nvm;
			spc_pkg::SFR_EDAT: sfr_rd = s.eedat;
			spc_pkg::SFR_EADL: sfr_rd = s.eeprom_address_low[7:0];
			spc_pkg::SFR_EADH: sfr_rd = s.eeprom_address_low[15:8];
			default:           sfr_rd = 8'h00;
		endcase
	endfunction

	// commands that turn the data pin around
	function automatic logic is_read(input logic [3:0] c);
		is_read = (c == spc_pkg::CMD_TABLE_READ_OP) || (c == spc_pkg::CMD_SHOUT);
	endfunction

	// edge seen only on the second and third stages
	assign fall   = q.sclk_s3 & ~q.sclk_s2;
	assign ld_sel = s_axi_wdata[spc_pkg::LOAD_SEL_HI:spc_pkg::LOAD_SEL_LO];
	assign ld_adr = s_axi_wdata[spc_pkg::LOAD_ADR_HI:spc_pkg::LOAD_ADR_LO];

	// byte picked by region; config space repeats every 16 bytes, other unimplemented space reads zero
	always_comb begin
		if (q.ptr[21:16] == spc_pkg::CFG_REGION) begin
			tbl_byte = cfg_mem[q.ptr[3:0]];
		end else if (q.ptr[21:16] == spc_pkg::ID_REGION
			&& q.ptr[15:3] == 13'h0) begin
			tbl_byte = id_mem[q.ptr[2:0]];
		end else if (q.ptr[21:16] == 6'h00) begin
			tbl_byte = pm_q;
		end else begin
			tbl_byte = 8'h00;
		end
	end

	// serial engine, core decoder and bus slave
	always_comb begin
		n         = q;
		cfg_we    = 1'b0;
		cfg_wa    = q.ptr[3:0];
		cfg_wd    = 8'h00;
		ee_rd     = 1'b0;
		tr_done   = 1'b0;
		core_exec = 1'b0;
		ld_we     = 1'b0;
		np        = {q.din_s2, q.pay[15:1]};
		// two flops before anything reads the pins
		n.sclk_s1 = prog_serial_clock;
		n.sclk_s2 = q.sclk_s1;
		n.sclk_s3 = q.sclk_s2;
		n.din_s1  = prog_serial_data_in;
		n.din_s2  = q.din_s1;
		if (!q.en) begin
			// disabled port stays idle and never drives the pin
			n.state = spc_pkg::SPC_ST_CMD;
			n.cnt   = 5'h00;
			n.oe    = 1'b0;
		end else if (fall) begin
			unique case (q.state)
				spc_pkg::SPC_ST_CMD: begin
					// command bits arrive lsb first
					n.cmd = {q.din_s2, q.cmd[3:1]};
					n.cnt = q.cnt + 5'h01;
					if (q.cnt == spc_pkg::CNT_CMD_LAST) begin
						n.state = spc_pkg::SPC_ST_PAY;
						n.cnt   = 5'h00;
					end
				end
				spc_pkg::SPC_ST_PAY: begin
					n.pay = np;
					n.cnt = q.cnt + 5'h01;
					if (q.cnt == spc_pkg::CNT_OPER8 && is_read(q.cmd)) begin
						// drive starts after the eighth operand fall
						n.sr   = (q.cmd == spc_pkg::CMD_TABLE_READ_OP) ? tbl_byte
							: q.tlat;
						n.dout = n.sr[0];
						n.oe   = 1'b1;
					end else if (q.oe) begin
						n.sr   = {1'b0, q.sr[7:1]};
						n.dout = q.sr[1];
					end
					if (q.cnt == spc_pkg::CNT_PAY_LAST) begin
						n.state = spc_pkg::SPC_ST_CMD;
						n.cnt   = 5'h00;
						n.cmd   = 4'h0;
						n.oe    = 1'b0;
						case (q.cmd)
							spc_pkg::CMD_CORE: core_exec = 1'b1;
							spc_pkg::CMD_TABLE_READ_OP: begin
								tr_done = 1'b1;
								// wrap keeps the pointer in program space
								n.ptr = (q.ptr == {6'h00, spc_pkg::PMEM_LAST})
									? 22'h0 : q.ptr + 22'h1;
							end
							spc_pkg::CMD_CFGWR: begin
								// pointer left alone: no increment here
								cfg_we = q.ptr[21:16] == spc_pkg::CFG_REGION
									&& q.nvm[spc_pkg::NVM_PGSEL]
									&& q.nvm[spc_pkg::NVM_CFSEL]
									&& q.nvm[spc_pkg::NVM_WRITE_ENABLE_BIT]
									&& cfg_mem[spc_pkg::PROT_IDX][spc_pkg::PROT_BIT];
								cfg_wd = q.ptr[0] ? np[15:8] : np[7:0];
							end
							default: ;
						endcase
					end
				end
			endcase
		end
		// one instruction per core command
		if (core_exec) begin
			if (np[15:8] == spc_pkg::OP_MOVLW) begin
				n.w = np[7:0];
			end else if (np[15:8] == spc_pkg::OP_MOVF) begin
				n.w = sfr_rd(q, np[7:0]);
			end else if (np[15:8] == spc_pkg::OP_MOVWF) begin
				unique case (np[7:0])
					spc_pkg::SFR_TLAT: n.tlat = q.w;
					spc_pkg::SFR_PTRL: n.ptr[7:0] = q.w;
					spc_pkg::SFR_PTRH: n.ptr[15:8] = q.w;
					spc_pkg::SFR_PTRU: n.ptr[21:16] = q.w[5:0];
					spc_pkg::SFR_NVM:  n.nvm = q.w;
					spc_pkg::SFR_EDAT: n.eedat = q.w;
					spc_pkg::SFR_EADL: n.eeprom_address_low[7:0] = q.w;
					spc_pkg::SFR_EADH: n.eeprom_address_low[15:8] = q.w;
					default: ;
				endcase
			end else if ((np[15:12] == spc_pkg::OP_BSF
				|| np[15:12] == spc_pkg::OP_BCF)
				&& np[7:0] == spc_pkg::SFR_NVM) begin
				n.nvm[np[11:9]] = (np[15:12] == spc_pkg::OP_BSF);
				if (np[11:9] == 3'(spc_pkg::NVM_RD)) begin
					// read bit self-clears; latch only from eeprom space
					n.nvm[spc_pkg::NVM_RD] = 1'b0;
					ee_rd = (np[15:12] == spc_pkg::OP_BSF)
						&& !q.nvm[spc_pkg::NVM_PGSEL]
						&& !q.nvm[spc_pkg::NVM_CFSEL];
					if (ee_rd) begin
						n.eedat = ee_q;
					end
				end
			end
		end
		// write channel: both taken together, answer one cycle later
		n.awready = 1'b0;
		n.wready  = 1'b0;
		n.arready = 1'b0;
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
			n.awready = 1'b1;
			n.wready  = 1'b1;
		end
		if (q.awready) begin
			n.bvalid = 1'b1;
			n.bresp  = spc_pkg::RESP_OKAY;
			unique case (s_axi_awaddr)
				spc_pkg::REG_CTRL: begin
					if (s_axi_wstrb[0]) begin
						n.en = s_axi_wdata[0];
					end
				end
				spc_pkg::REG_LOAD: ld_we = &s_axi_wstrb;
				spc_pkg::REG_PTR, spc_pkg::REG_STAT: ;
				default: n.bresp = spc_pkg::RESP_SLVERR;
			endcase
		end
		// read channel
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.arready && !q.rvalid) begin
			n.arready = 1'b1;
		end
		if (q.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = spc_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				spc_pkg::REG_CTRL: n.rdata = {31'h0, q.en};
				spc_pkg::REG_PTR:  n.rdata = {10'h0, q.ptr};
				spc_pkg::REG_STAT: n.rdata = {q.nvm, q.tlat, q.eedat, q.w};
				spc_pkg::REG_LOAD: n.rdata = 32'h0;
				default: begin
					n.rdata = 32'h0;
					n.rresp = spc_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// state register, synchronous reset to constants
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q       <= '0;
			q.state <= spc_pkg::SPC_ST_CMD;
			q.en    <= spc_pkg::CTRL_RESET;
		end else begin
			q <= n;
		end
	end

	// memories; reads are registered so the pointer settles first
	always_ff @(posedge aclk) begin
		pm_q <= pm_mem[q.ptr[15:0]];
		ee_q <= ee_mem[q.eeprom_address_low[7:0]];
		if (ld_we && ld_sel == spc_pkg::LOAD_PMEM) begin
			pm_mem[ld_adr] <= s_axi_wdata[7:0];
		end
		if (ld_we && ld_sel == spc_pkg::LOAD_EE) begin
			ee_mem[ld_adr[7:0]] <= s_axi_wdata[7:0];
		end
		if (ld_we && ld_sel == spc_pkg::LOAD_ID) begin
			id_mem[ld_adr[2:0]] <= s_axi_wdata[7:0];
		end
	end

	// config bytes erase to all ones at reset
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 16; i++) begin
			if (!aresetn) begin
				cfg_mem[i] <= spc_pkg::CFG_RESET;
			end else if (cfg_we && cfg_wa == 4'(i)) begin
				cfg_mem[i] <= cfg_wd;
			end
		end
	end

	assign prog_serial_data_out = q.dout;
	assign prog_serial_data_oe  = q.oe;
	assign s_axi_awready        = q.awready;
	assign s_axi_wready         = q.wready;
	assign s_axi_bvalid         = q.bvalid;
	assign s_axi_bresp          = q.bresp;
	assign s_axi_arready        = q.arready;
	assign s_axi_rvalid         = q.rvalid;
	assign s_axi_rresp          = q.rresp;
	assign s_axi_rdata          = q.rdata;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// a disabled port resets framing, so only count enabled falls
	sequence s_cmd_end;
		q.en && q.state == spc_pkg::SPC_ST_CMD && fall
			&& q.cnt == spc_pkg::CNT_CMD_LAST;
	endsequence
	// last payload fall of a config write frame
	sequence s_cfg_end;
		q.en && fall && q.cmd == spc_pkg::CMD_CFGWR
			&& q.cnt == spc_pkg::CNT_PAY_LAST;
	endsequence
	sequence s_drive_on;
		$rose(q.oe);
	endsequence

	cfg_write_cmd_a: assert property (cfg_we |-> q.cmd == spc_pkg::CMD_CFGWR
		&& q.cnt == spc_pkg::CNT_PAY_LAST) else $error("config write off command");
	byte_select_a: assert property (cfg_we |=> cfg_mem[q.ptr[3:0]]
		== (q.ptr[0] ? q.pay[15:8] : q.pay[7:0])) else $error("wrong payload byte");
	protect_block_a: assert property (s_cfg_end
		##0 !cfg_mem[spc_pkg::PROT_IDX][spc_pkg::PROT_BIT]
		|=> cfg_mem[q.ptr[3:0]] == $past(cfg_mem[q.ptr[3:0]]))
		else $error("write past protection");
	cmd_length_a: assert property (s_cmd_end |=> q.state == spc_pkg::SPC_ST_PAY
		&& q.cnt == 5'h00) else $error("command not four bits");
	drive_start_a: assert property (s_drive_on |-> q.cnt == 5'h08
		&& is_read(q.cmd) && q.dout == q.sr[0]) else $error("drive at wrong clock");
	drive_end_a: assert property (q.oe && fall
		&& q.cnt == spc_pkg::CNT_PAY_LAST |=> !q.oe) else $error("drive past frame");
	ptr_step_a: assert property (tr_done |=> q.ptr == (($past(q.ptr)
		== {6'h00, spc_pkg::PMEM_LAST}) ? 22'h0 : $past(q.ptr) + 22'h1))
		else $error("pointer step wrong");
	ptr_wrap_a: assert property (tr_done && q.ptr == {6'h00, spc_pkg::PMEM_LAST}
		|=> q.ptr == 22'h0) else $error("pointer did not wrap");
	ee_latch_a: assert property (ee_rd |=> q.eedat == $past(ee_q))
		else $error("eeprom latch not loaded");
	movlw_exec_a: assert property (core_exec && np[15:8] == spc_pkg::OP_MOVLW
		|=> q.w == $past(np[7:0])) else $error("literal not loaded");
	resp_follow_a: assert property (q.awready |=> q.bvalid)
		else $error("write response missing");
endmodule
`default_nettype wire

// [common/spc_pkg.sv]
`default_nettype none
package spc_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] REG_CTRL = 8'h00; // bit0 port enable
	localparam logic [7:0] REG_PTR  = 8'h04; // table pointer, read only
	localparam logic [7:0] REG_STAT = 8'h08; // nvm ctrl, latches, w
	localparam logic [7:0] REG_LOAD = 8'h0c; // memory preload, write only
	// preload word fields
	localparam int LOAD_SEL_HI  = 31;
	localparam int LOAD_SEL_LO  = 30;
	localparam int LOAD_ADR_HI  = 23;
	localparam int LOAD_ADR_LO  = 8;
	localparam logic [1:0] LOAD_PMEM = 2'h0;
	localparam logic [1:0] LOAD_EE   = 2'h1;
	localparam logic [1:0] LOAD_ID   = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic       CTRL_RESET  = 1'h1;
	// four-bit serial commands
	localparam logic [3:0] CMD_CORE  = 4'h0;
	localparam logic [3:0] CMD_SHOUT = 4'h2;
	localparam logic [3:0] CMD_TABLE_READ_OP = 4'h9;
	localparam logic [3:0] CMD_CFGWR = 4'hf;
	// core instruction opcodes and register file addresses
	localparam logic [7:0] OP_MOVLW = 8'h0e;
	localparam logic [7:0] OP_MOVWF = 8'h6e;
	localparam logic [7:0] OP_MOVF  = 8'h50;
	localparam logic [3:0] OP_BSF   = 4'h8;
	localparam logic [3:0] OP_BCF   = 4'h9;
	localparam logic [7:0] SFR_TLAT = 8'hf5;
	localparam logic [7:0] SFR_PTRL = 8'hf6;
	localparam logic [7:0] SFR_PTRH = 8'hf7;
	localparam logic [7:0] SFR_PTRU = 8'hf8;
	localparam logic [7:0] SFR_NVM  = 8'ha6;
	localparam logic [7:0] SFR_EDAT = 8'ha8;
	localparam logic [7:0] SFR_EADL = 8'ha9;
	localparam logic [7:0] SFR_EADH = 8'haa;
	// nvm control bit positions
	localparam int NVM_PGSEL = 7;
	localparam int NVM_CFSEL = 6;
	localparam int NVM_WRITE_ENABLE_BIT  = 2;
	localparam int NVM_RD    = 0;
	// address map
	localparam logic [5:0]  CFG_REGION = 6'h30;
	localparam logic [5:0]  ID_REGION  = 6'h20;
	localparam logic [3:0]  PROT_IDX   = 4'hb;
	localparam int          PROT_BIT   = 5;
	localparam logic [7:0]  CFG_RESET  = 8'hff;
	localparam logic [15:0] PMEM_LAST  = 16'hffff;
	localparam int          EE_DEPTH   = 256;
	localparam logic [4:0]  CNT_CMD_LAST = 5'h03;
	localparam logic [4:0]  CNT_OPER8    = 5'h07;
	localparam logic [4:0]  CNT_PAY_LAST = 5'h0f;

	typedef enum logic [1:0] {
		SPC_ST_CMD = 2'b01,
		SPC_ST_PAY = 2'b10
	} spc_phase_t;

	typedef struct packed {
		logic       sclk_s1, sclk_s2, sclk_s3;
		logic       din_s1, din_s2;
		spc_phase_t state;
		logic [4:0] cnt;
		logic [3:0] cmd;
		logic [15:0] pay;
		logic [7:0] sr;
		logic       dout, oe;
		logic [7:0] w, tlat, eedat, nvm;
		logic [21:0] ptr;
		logic [15:0] eeprom_address_low;
		logic       en;
		logic       awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} spc_state_t;
endpackage
`default_nettype wire

// [sim/spc_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_prog_model #(
	parameter int HOLD_NS = 1000, // program_hold_time, shortened
	parameter int ALT_NS  = 1500, // alt_program_hold_time
	parameter int DIS_NS  = 500,  // discharge_time
	parameter int TURN_NS = 300   // turnaround_delay
) (
	output logic      sclk, // prog_serial_clock, rests low
	output logic      sd,   // programmer side of the data line
	input  wire logic line  // resolved data line
);
	// serial clock stands still between frames
	initial begin
		sclk = 1'b0;
		sd = 1'b0;
	end
	// one frame; hold 1 or 2 stretches the last clock for programming
	task automatic frame(input logic [3:0] c, input logic [15:0] p,
		input int hold, output logic [7:0] q);
		logic [19:0] b;
		bit          rd;
		b = {p, c};
		rd = (c == spc_pkg::CMD_TABLE_READ_OP) || (c == spc_pkg::CMD_SHOUT);
		q = 8'h00;
		for (int i = 0; i < 20; i++) begin
			// data moves at the rise, well clear of the sampling fall
			if (!(rd && i >= 12))
				sd = b[i];
			sclk = 1'b1;
			#((i != 19 || hold == 0) ? 100 : (hold == 1) ? HOLD_NS : ALT_NS);
			if (rd && i >= 12)
				q[i - 12] = line;
			sclk = 1'b0;
			// released line shows the inverse, not a stale level
			if (rd && i == 11) begin
				sd = ~sd;
				#(TURN_NS);
			end
			#((i == 19 && hold != 0) ? DIS_NS : 100);
		end
	endtask
	task automatic core(input logic [15:0] p, input int hold = 0);
		logic [7:0] q;
		frame(spc_pkg::CMD_CORE, p, hold, q);
	endtask
	// whole pointer loaded every time, no increment assumed
	task automatic set_ptr(input logic [21:0] a);
		core({spc_pkg::OP_MOVLW, 2'h0, a[21:16]});
		core({spc_pkg::OP_MOVWF, spc_pkg::SFR_PTRU});
		core({spc_pkg::OP_MOVLW, a[15:8]});
		core({spc_pkg::OP_MOVWF, spc_pkg::SFR_PTRH});
		core({spc_pkg::OP_MOVLW, a[7:0]});
		core({spc_pkg::OP_MOVWF, spc_pkg::SFR_PTRL});
	endtask
	task automatic table_read_op(output logic [7:0] q);
		frame(spc_pkg::CMD_TABLE_READ_OP, 16'h0000, 0, q);
	endtask
	// two byte reads merged into one word
	task automatic read_word(output logic [15:0] w);
		logic [7:0] lo, hi;
		table_read_op(lo);
		table_read_op(hi);
		w = {hi, lo};
	endtask
	// program space, config space, write enable
	task automatic cfg_enable();
		core(16'h8ea6);
		core(16'h8ca6);
		core(16'h84a6);
	endtask
	task automatic cfg_write(input logic [21:0] a, input logic [15:0] p);
		logic [7:0] q;
		set_ptr(a);
		frame(spc_pkg::CMD_CFGWR, p, 0, q);
		core(16'h0000, a[0] ? 2 : 1);
	endtask
	// eeprom byte goes latch, w, table latch, then out
	task automatic ee_read(input logic [15:0] a, output logic [7:0] q);
		core(16'h9ea6);
		core(16'h9ca6);
		core({spc_pkg::OP_MOVLW, a[7:0]});
		core({spc_pkg::OP_MOVWF, spc_pkg::SFR_EADL});
		core({spc_pkg::OP_MOVLW, a[15:8]});
		core({spc_pkg::OP_MOVWF, spc_pkg::SFR_EADH});
		core(16'h80a6);
		core({spc_pkg::OP_MOVF, spc_pkg::SFR_EDAT});
		core({spc_pkg::OP_MOVWF, spc_pkg::SFR_TLAT});
		core(16'h0000);
		frame(spc_pkg::CMD_SHOUT, 16'h0000, 0, q);
	endtask
endmodule
`default_nettype wire

// [sim/spc_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_port_tb_top;
	logic        aclk, aresetn;          // system clock and reset
	logic        sclk, sd, dout, oe;     // serial link pieces
	wire logic   line;                   // resolved data line
	logic [7:0]  awaddr, araddr;         // register offsets
	logic [31:0] wdata, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;                  // write strobes
	int          n_mismatch, n_checks;
	int          cyc = 0;                // timeout counter
	// device wins the line only while it enables it
	assign line = oe ? dout : sd;
	spc_port u_spc_port (.aclk(aclk), .aresetn(aresetn),
		.prog_serial_clock(sclk), .prog_serial_data_in(line),
		.prog_serial_data_out(dout), .prog_serial_data_oe(oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	spc_prog_model u_spc_prog_model (.sclk(sclk), .sd(sd), .line(line));
	// 25 ns system clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// a hang ends the run as a mismatch
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic load(input logic [1:0] s, input logic [15:0] a,
		input logic [7:0] v);
		logic [1:0] r;
		wr(spc_pkg::REG_LOAD, {s, 6'h00, a, v}, r);
	endtask
	// reset values, unmapped and write-only places
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rd(spc_pkg::REG_CTRL, d, r);
		chk("ctrl", 32'h00000001, d);
		rd(spc_pkg::REG_PTR, d, r);
		chk("ptr", 32'h00000000, d);
		rd(spc_pkg::REG_STAT, d, r);
		chk("stat", 32'h00000000, d);
		rd(spc_pkg::REG_LOAD, d, r);
		chk("load", 32'h00000000, {d[31:2], r});
		rd(8'h10, d, r);
		chk("unmapped rd", {30'h0, spc_pkg::RESP_SLVERR}, {d[31:2], r});
		wr(8'h10, 32'h00000001, r);
		chk("unmapped wr", {30'h0, spc_pkg::RESP_SLVERR}, {30'h0, r});
	endtask
	// last program byte, wrap to zero, two reads merged
	task automatic t_wrap();
		logic [15:0] w;
		logic [31:0] d;
		logic [1:0]  r;
		u_spc_prog_model.set_ptr(22'h00ffff);
		u_spc_prog_model.read_word(w);
		chk("word", 32'h00003ca5, {16'h0, w});
		rd(spc_pkg::REG_PTR, d, r);
		chk("ptr", 32'h00000001, d);
		u_spc_prog_model.set_ptr(22'h200000);
		u_spc_prog_model.table_read_op(w[7:0]);
		chk("id", 32'h0000005a, {24'h0, w[7:0]});
	endtask
	// even and odd config bytes, then protection
	task automatic t_cfg();
		logic [7:0]  q;
		logic [31:0] d;
		logic [1:0]  r;
		u_spc_prog_model.cfg_enable();
		rd(spc_pkg::REG_STAT, d, r);
		chk("nvm", 32'h000000c4, {24'h0, d[31:24]});
		u_spc_prog_model.cfg_write(22'h300000, 16'h1234);
		u_spc_prog_model.cfg_write(22'h300001, 16'h5678);
		u_spc_prog_model.set_ptr(22'h300000);
		u_spc_prog_model.table_read_op(q);
		chk("cfg0", 32'h00000034, {24'h0, q});
		u_spc_prog_model.table_read_op(q);
		chk("cfg1", 32'h00000056, {24'h0, q});
		u_spc_prog_model.table_read_op(q);
		chk("cfg2", 32'h000000ff, {24'h0, q});
		// everything else written before protection is set
		u_spc_prog_model.cfg_write(22'h30000b, 16'hdf00);
		u_spc_prog_model.cfg_write(22'h300000, 16'h0099);
		u_spc_prog_model.set_ptr(22'h300000);
		u_spc_prog_model.table_read_op(q);
		chk("cfg0 locked", 32'h00000034, {24'h0, q});
	endtask
	// eeprom read through the holding register
	task automatic t_ee();
		logic [7:0]  q;
		logic [31:0] d;
		logic [1:0]  r;
		u_spc_prog_model.ee_read(16'h0012, q);
		chk("ee out", 32'h000000c3, {24'h0, q});
		rd(spc_pkg::REG_STAT, d, r);
		chk("latches", 32'h00c3c3c3, {8'h0, d[23:0]});
	endtask
	// disabled port ignores a read frame
	task automatic t_off();
		logic [7:0]  q;
		logic [31:0] d, p;
		logic [1:0]  r;
		rd(spc_pkg::REG_PTR, p, r);
		wr(spc_pkg::REG_CTRL, 32'h00000000, r);
		u_spc_prog_model.table_read_op(q);
		// an undriven line keeps the model's inverted level
		chk("line off", 32'h000000ff, {24'h0, q});
		rd(spc_pkg::REG_PTR, d, r);
		chk("ptr off", p, d);
		rd(spc_pkg::REG_CTRL, d, r);
		chk("ctrl", 32'h00000000, d);
		wr(spc_pkg::REG_CTRL, 32'h00000001, r);
		// without strobe 0 the enable bit is left alone
		wstrb <= 4'he;
		wr(spc_pkg::REG_CTRL, 32'h00000000, r);
		wstrb <= 4'hf;
		rd(spc_pkg::REG_CTRL, d, r);
		chk("ctrl strobe", 32'h00000001, d);
	endtask
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		load(spc_pkg::LOAD_PMEM, 16'hffff, 8'ha5);
		load(spc_pkg::LOAD_PMEM, 16'h0000, 8'h3c);
		load(spc_pkg::LOAD_ID, 16'h0000, 8'h5a);
		load(spc_pkg::LOAD_EE, 16'h0012, 8'hc3);
		t_wrap();
		t_cfg();
		t_ee();
		t_off();
		summarize();
	end
endmodule
`default_nettype wire
